// File: src/rcr_defs.svh
// Summary of operation
// - enable bit starts and stops measurement
// - standard set: 56/54/52/50 kHz carrier
// - periodic set: 64/56.9/51.2/46.5 kHz carrier
// - bit 16 chooses standard or periodic set
// - bit 15 drives carrier sync on pin three
// - bit 14 bypasses the on-chip amplifier
// - bit 13 pairs right-arm with leg or arm when capacitors are internal
// - bit 12 picks internal or external capacitors
// - gain field sets amplifier gain one to ten
// - bit 7 picks external leg or arm path
// - lead field picks lead or external path
// - amplitude field scales drive tone by powers of two, an eighth to full
// - register answers at address 0x03
`ifndef RCR_DEFS_SVH
`define RCR_DEFS_SVH

// ==========================================================
// register map
`define RCR_REG_ADDR 8'h03
`define RCR_RESET 24'h000000
`define RCR_WMASK 24'h01ffff

// ==========================================================
// field positions
`define RCR_EN_BIT 0
`define RCR_FREQ_LSB 1
`define RCR_AMP_LSB 3
`define RCR_LEAD_LSB 5
`define RCR_EXTSEL_BIT 7
`define RCR_GAIN_LSB 8
`define RCR_CAP_BIT 12
`define RCR_PAIR_BIT 13
`define RCR_BYP_BIT 14
`define RCR_SYNC_BIT 15
`define RCR_ALT_BIT 16

// ==========================================================
// gain limits
`define RCR_GAIN_MAX 4'ha
`define RCR_GAIN_LAST_CODE 4'h9

// ==========================================================
// carrier timing: frequencies in hertz, counts derived
`define RCR_CLK_HZ 50000000
`define RCR_F_STD0_HZ 56000
`define RCR_F_STD1_HZ 54000
`define RCR_F_STD2_HZ 52000
`define RCR_F_STD3_HZ 50000
`define RCR_F_ALT0_HZ 64000
`define RCR_F_ALT1_HZ 56900
`define RCR_F_ALT2_HZ 51200
`define RCR_F_ALT3_HZ 46500
`define RCR_HALF_CYC(f) (`RCR_CLK_HZ / (2 * (f)))

`endif

// File: src/rcr_pkg.sv
package rcr_pkg;
  // measurement lead choice
  typedef enum logic [1:0] {
    RCR_LEAD_I,
    RCR_LEAD_II,
    RCR_LEAD_III,
    RCR_LEAD_EXT
  } rcr_lead_e;

  // one register bus request
  typedef struct packed {
    logic [7:0] addr;
    logic [23:0] wdata;
    logic wr;
    logic rd;
  } rcr_bus_s;

  // decoded analog front-end controls
  typedef struct packed {
    logic measure_enable;
    logic periodic_set;
    logic [1:0] frequency_code;
    logic sync_enable;
    logic amplifier_bypass;
    logic capacitor_external;
    logic right_arm_drive;
    logic left_leg_drive;
    logic left_arm_drive;
    logic [3:0] gain;
    rcr_lead_e lead;
    logic external_right_arm_path;
    logic external_left_leg_path;
    logic external_left_arm_path;
    logic [1:0] amplitude_shift;
  } rcr_cfg_s;
endpackage

// File: src/rcr_decode.sv
`timescale 1ns/1ps
`default_nettype none
`include "rcr_defs.svh"

// ==========================================================
// field decode of the control word, purely combinational
module rcr_decode (
  input wire logic [23:0] i_word,
  output var rcr_pkg::rcr_cfg_s o_cfg
);
  // gain from code: listed codes and the gaps both follow code plus one
  function automatic logic [3:0] gain_of(input logic [3:0] code);
    if (code > `RCR_GAIN_LAST_CODE) begin
      gain_of = `RCR_GAIN_MAX;
    end else begin
      gain_of = code + 4'h1;
    end
  endfunction

  logic ext_sel; // lead field picks the external path

  // decode every field
  always_comb begin
    ext_sel = (i_word[`RCR_LEAD_LSB +: 2] == 2'h3);
    o_cfg.measure_enable = i_word[`RCR_EN_BIT];
    o_cfg.periodic_set = i_word[`RCR_ALT_BIT];
    o_cfg.frequency_code = i_word[`RCR_FREQ_LSB +: 2];
    o_cfg.sync_enable = i_word[`RCR_SYNC_BIT];
    o_cfg.amplifier_bypass = i_word[`RCR_BYP_BIT];
    o_cfg.capacitor_external = i_word[`RCR_CAP_BIT];
    // right arm always drives; external caps force right arm alone
    o_cfg.right_arm_drive = 1'b1;
    o_cfg.left_leg_drive = !i_word[`RCR_CAP_BIT] && !i_word[`RCR_PAIR_BIT];
    o_cfg.left_arm_drive = !i_word[`RCR_CAP_BIT] && i_word[`RCR_PAIR_BIT];
    o_cfg.gain = gain_of(i_word[`RCR_GAIN_LSB +: 4]);
    o_cfg.lead = rcr_pkg::rcr_lead_e'(i_word[`RCR_LEAD_LSB +: 2]);
    // external limb choice only counts on the external path
    o_cfg.external_right_arm_path = ext_sel;
    o_cfg.external_left_leg_path = ext_sel && !i_word[`RCR_EXTSEL_BIT];
    o_cfg.external_left_arm_path = ext_sel && i_word[`RCR_EXTSEL_BIT];
    // right shift of full scale: code 00 is /8, code 11 is full
    o_cfg.amplitude_shift = 2'h3 - i_word[`RCR_AMP_LSB +: 2];
  end
endmodule
`default_nettype wire

// File: src/rcr_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
`include "rcr_defs.svh"

// ==========================================================
// respiration control register with carrier sync generator
module rcr_ctrl #(
  parameter int CNT_W = 10 // wide enough for the slowest half period
) (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire rcr_pkg::rcr_bus_s i_bus,
  output logic [23:0] o_rdata,
  output var rcr_pkg::rcr_cfg_s o_cfg,
  output logic o_carrier,
  output logic o_pin3_out,
  output logic o_pin3_oe,
  input wire logic i_pin3_in
);

  // ==========================================================
  // state
  logic [23:0] ctl_q; // the control word
  logic [23:0] ctl_d;
  logic [23:0] rdata_q; // read data, one cycle after strobe
  logic [23:0] rdata_d;
  rcr_pkg::rcr_cfg_s cfg_q; // registered decode
  rcr_pkg::rcr_cfg_s cfg_w;
  logic [CNT_W-1:0] cnt_q; // carrier half-period counter
  logic [CNT_W-1:0] cnt_d;
  logic car_q; // carrier phase
  logic car_d;
  logic pin_q; // pin drive level
  logic pin_d;
  logic oe_q; // pin enable
  logic oe_d;
  logic [CNT_W-1:0] half; // current half period
  logic hit; // bus address matches the register
  logic pin_seen; // pin input, not used by this block

  // half period for a frequency code; integer divide rounds down
  function automatic logic [CNT_W-1:0] half_of(input logic alt, input logic [1:0] code);
    logic [CNT_W-1:0] h;
    h = '0;
    if (!alt) begin
      case (code)
        2'h0: h = CNT_W'(`RCR_HALF_CYC(`RCR_F_STD0_HZ));
        2'h1: h = CNT_W'(`RCR_HALF_CYC(`RCR_F_STD1_HZ));
        2'h2: h = CNT_W'(`RCR_HALF_CYC(`RCR_F_STD2_HZ));
        default: h = CNT_W'(`RCR_HALF_CYC(`RCR_F_STD3_HZ));
      endcase
    end else begin
      case (code)
        2'h0: h = CNT_W'(`RCR_HALF_CYC(`RCR_F_ALT0_HZ));
        2'h1: h = CNT_W'(`RCR_HALF_CYC(`RCR_F_ALT1_HZ));
        2'h2: h = CNT_W'(`RCR_HALF_CYC(`RCR_F_ALT2_HZ));
        default: h = CNT_W'(`RCR_HALF_CYC(`RCR_F_ALT3_HZ));
      endcase
    end
    return h;
  endfunction

  // ==========================================================
  // field decode
  rcr_decode u_decode (
    .i_word(ctl_q),
    .o_cfg(cfg_w)
  );

  // ==========================================================
  // register bus
  // only one address exists; others read zero and drop writes
  always_comb begin
    hit = (i_bus.addr == `RCR_REG_ADDR);
    ctl_d = ctl_q;
    rdata_d = '0;
    if (i_bus.wr && hit) begin
      // reserved bits never store, so they always read back zero
      ctl_d = i_bus.wdata & `RCR_WMASK;
    end
    if (i_bus.rd && hit) begin
      rdata_d = ctl_q & `RCR_WMASK;
    end
  end

  // bus registers; read data holds only in the cycle after the strobe
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ctl_q <= `RCR_RESET;
      rdata_q <= '0;
    end else begin
      ctl_q <= ctl_d;
      rdata_q <= rdata_d;
    end
  end

  // ==========================================================
  // carrier generator
  // a fixed divider per code; every code but 50 kHz lands slightly off its
  // nominal rate because the division is rounded, which is accepted
  always_comb begin
    half = half_of(ctl_q[`RCR_ALT_BIT], ctl_q[`RCR_FREQ_LSB +: 2]);
    cnt_d = cnt_q;
    car_d = car_q;
    if (!ctl_q[`RCR_EN_BIT]) begin
      // measurement off: carrier parked low, counter cleared
      cnt_d = '0;
      car_d = 1'b0;
    end else if (cnt_q >= half - CNT_W'(1)) begin
      // end of half period; >= also catches a shortened code change
      cnt_d = '0;
      car_d = !car_q;
    end else begin
      cnt_d = cnt_q + CNT_W'(1);
    end
  end

  // carrier registers
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cnt_q <= '0;
      car_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      car_q <= car_d;
    end
  end

  // ==========================================================
  // sync pin three
  // the pin is released unless sync is asked for and the carrier runs
  always_comb begin
    oe_d = ctl_q[`RCR_SYNC_BIT] && ctl_q[`RCR_EN_BIT];
    pin_d = oe_d && car_q;
    pin_seen = i_pin3_in;
  end

  // pin and decode registers keep data outputs glitch free
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      oe_q <= 1'b0;
      pin_q <= 1'b0;
      cfg_q <= '0;
    end else begin
      oe_q <= oe_d;
      pin_q <= pin_d;
      cfg_q <= cfg_w;
    end
  end

  // ==========================================================
  // outputs
  assign o_rdata = rdata_q;
  assign o_cfg = cfg_q;
  assign o_carrier = car_q;
  assign o_pin3_out = pin_q;
  assign o_pin3_oe = oe_q;

  // ==========================================================
  // checks
  // read of the register returns the stored word next cycle
  read_back_a: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    (i_bus.rd && i_bus.addr == `RCR_REG_ADDR) |=> (o_rdata == $past(ctl_q)))
    else $error("register read data wrong");

  // unmapped reads answer zero
  unmapped_read_a: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    (i_bus.rd && i_bus.addr != `RCR_REG_ADDR) |=> (o_rdata == 24'h000000))
    else $error("unmapped read not zero");

  // reserved bits never reach the read port
  reserved_zero_a: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    (o_rdata[23:17] == 7'h00))
    else $error("reserved bits read nonzero");

  // a write stores the low seventeen bits
  write_store_a: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    (i_bus.wr && i_bus.addr == `RCR_REG_ADDR)
      |=> (ctl_q == ($past(i_bus.wdata) & `RCR_WMASK)))
    else $error("write not stored");

  // measurement off for two cycles leaves carrier and pin quiet
  enable_off_a: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    (!ctl_q[`RCR_EN_BIT] ##1 !ctl_q[`RCR_EN_BIT])
      |=> (!o_carrier && !o_pin3_oe && !o_cfg.measure_enable))
    else $error("carrier active while disabled");

  // carrier flips exactly at the end of each half period
  carrier_toggle_a: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    (ctl_q[`RCR_EN_BIT] && cnt_q == half - CNT_W'(1)) |=> (o_carrier != $past(car_q)))
    else $error("carrier did not toggle");

  // carrier holds while the count runs
  carrier_hold_a: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    (ctl_q[`RCR_EN_BIT] && cnt_q < half - CNT_W'(1)) |=> $stable(o_carrier))
    else $error("carrier toggled early");

  // sync pin follows the enable bits one cycle later
  sync_pin_a: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    (ctl_q[`RCR_SYNC_BIT] && ctl_q[`RCR_EN_BIT]) |=> (o_pin3_oe && o_pin3_out == $past(car_q)))
    else $error("sync pin not driven");

  // gain stays within one to ten and top codes saturate
  gain_range_a: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    (ctl_q[`RCR_GAIN_LSB +: 4] >= 4'ha) |=> (o_cfg.gain == 4'ha))
    else $error("gain not saturated");

  // gap codes give code plus one
  gain_gap_a: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    (ctl_q[`RCR_GAIN_LSB +: 4] == 4'h5) |=> (o_cfg.gain == 4'h6))
    else $error("gap gain wrong");

  // external capacitors leave only the right-arm drive
  cap_pairing_a: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    ctl_q[`RCR_CAP_BIT] |=> (o_cfg.capacitor_external && !o_cfg.left_leg_drive
      && !o_cfg.left_arm_drive && o_cfg.right_arm_drive))
    else $error("capacitor pairing wrong");

  // external limb path only on the external lead code
  ext_path_a: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    (ctl_q[`RCR_LEAD_LSB +: 2] != 2'h3)
      |=> (!o_cfg.external_left_arm_path && !o_cfg.external_left_leg_path))
    else $error("external path active on a lead");

  // amplitude code 00 gives an eighth
  amp_scale_a: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    (ctl_q[`RCR_AMP_LSB +: 2] == 2'h0) |=> (o_cfg.amplitude_shift == 2'h3))
    else $error("amplitude scale wrong");

  // bypass follows its bit
  bypass_a: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    1'b1 |=> (o_cfg.amplifier_bypass == $past(ctl_q[`RCR_BYP_BIT])))
    else $error("bypass mismatch");

  // read data is zero in any cycle that no read strobe precedes
  rdata_idle_a: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    !i_bus.rd |=> (o_rdata == 24'h000000))
    else $error("read data not idle");

  // writes to other addresses leave the word alone
  unmapped_write_a: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    (i_bus.wr && i_bus.addr != `RCR_REG_ADDR) |=> $stable(ctl_q))
    else $error("unmapped write changed the word");

  // without sync asked for, the pin is released and low
  pin_release_a: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    !(ctl_q[`RCR_SYNC_BIT] && ctl_q[`RCR_EN_BIT]) |=> (!o_pin3_oe && !o_pin3_out))
    else $error("sync pin driven while off");

  // lead field reaches the decode unchanged
  lead_decode_a: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    1'b1 |=> (o_cfg.lead == $past(ctl_q[`RCR_LEAD_LSB +: 2])))
    else $error("lead decode wrong");

  // frequency set and code reach the decode unchanged
  freq_decode_a: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    1'b1 |=> (o_cfg.periodic_set == $past(ctl_q[`RCR_ALT_BIT])
      && o_cfg.frequency_code == $past(ctl_q[`RCR_FREQ_LSB +: 2])))
    else $error("frequency decode wrong");

  // internal capacitors: pairing bit picks leg or arm beside right arm
  pair_select_a: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    !ctl_q[`RCR_CAP_BIT] |=> (o_cfg.right_arm_drive
      && o_cfg.left_arm_drive == $past(ctl_q[`RCR_PAIR_BIT])
      && o_cfg.left_leg_drive != $past(ctl_q[`RCR_PAIR_BIT])))
    else $error("drive pairing wrong");

  // external lead code: right arm path plus the chosen limb
  ext_limb_a: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    (ctl_q[`RCR_LEAD_LSB +: 2] == 2'h3) |=> (o_cfg.external_right_arm_path
      && o_cfg.external_left_arm_path == $past(ctl_q[`RCR_EXTSEL_BIT])
      && o_cfg.external_left_leg_path != $past(ctl_q[`RCR_EXTSEL_BIT])))
    else $error("external limb path wrong");

  // codes up to the last listed one give code plus one
  gain_step_a: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    (ctl_q[`RCR_GAIN_LSB +: 4] <= `RCR_GAIN_LAST_CODE)
      |=> (o_cfg.gain == $past(ctl_q[`RCR_GAIN_LSB +: 4]) + 4'h1))
    else $error("gain step wrong");

  // amplitude code 11 drives full scale
  amp_full_a: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    (ctl_q[`RCR_AMP_LSB +: 2] == 2'h3) |=> (o_cfg.amplitude_shift == 2'h0))
    else $error("full amplitude wrong");
endmodule
`default_nettype wire

// File: verif/tb_top.sv
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// testbench for the respiration control register
module tb_top;
  localparam logic [7:0] REG_ADDR = 8'h03; // only mapped register
  logic i_clk; // 50 MHz system clock
  logic i_reset_n; // active-low reset
  rcr_pkg::rcr_bus_s bus; // register bus request
  logic [23:0] o_rdata; // read data
  rcr_pkg::rcr_cfg_s cfg; // decoded controls
  logic o_carrier; // internal carrier
  logic o_pin3_out; // sync pin level
  logic o_pin3_oe; // sync pin enable
  int mismatches;
  int check_count;
  // carrier rates: standard set then periodic set
  int freq_hz [8] = '{56000, 54000, 52000, 50000, 64000, 56900, 51200, 46500};

  rcr_ctrl u_dut (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_bus(bus),
    .o_rdata(o_rdata),
    .o_cfg(cfg),
    .o_carrier(o_carrier),
    .o_pin3_out(o_pin3_out),
    .o_pin3_oe(o_pin3_oe),
    .i_pin3_in(1'b0)
  );

  // ==========================================================
  // clock, watchdog and closing
  initial begin
    i_clk = 1'b0;
    forever #10 i_clk = ~i_clk;
  end

  // the whole run takes about 7700 cycles; allow about two and a half times that
  initial begin
    #400000;
    mismatches++;
    report_and_stop();
  end

  task automatic report_and_stop();
    if (mismatches == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // one comparison; four-state compare so unknowns never match
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  // ==========================================================
  // bus tasks: one-cycle strobes launched right after an edge
  task automatic wr(input logic [7:0] a, input logic [23:0] d);
    @(posedge i_clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge i_clk);
    bus <= '{default: '0};
  endtask

  // returns the data standing in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [23:0] d);
    @(posedge i_clk);
    bus <= '{addr: a, wdata: 24'h000000, wr: 1'b0, rd: 1'b1};
    @(posedge i_clk);
    bus <= '{default: '0};
    #1;
    d = o_rdata;
  endtask

  // write the register and wait until the decode has landed
  task automatic setw(input logic [23:0] d);
    wr(REG_ADDR, d);
    @(posedge i_clk);
    #1;
  endtask

  // ==========================================================
  // carrier half period for one code of one set
  task automatic carrier(input int idx);
    int n;
    setw({7'h00, idx[2], 1'b1, 12'h000, idx[1:0], 1'b1});
    chk(o_pin3_oe, 1);
    chk(cfg.sync_enable, 1);
    chk(cfg.periodic_set, idx[2]);
    chk(cfg.frequency_code, idx[1:0]);
    n = 0;
    while (o_carrier !== 1'b1 && n < 2000) begin
      @(posedge i_clk);
      #1;
      n++;
    end
    n = 0;
    // count how long the high level stands
    while (o_carrier === 1'b1 && n < 2000) begin
      @(posedge i_clk);
      #1;
      if (n == 0) begin
        // the pin copies the carrier one cycle behind it
        chk(o_pin3_out, 1);
      end
      n++;
    end
    chk(n, 50000000 / (2 * freq_hz[idx]));
    setw(24'h000000);
    chk(o_carrier, 0);
    chk(o_pin3_oe, 0);
    chk(o_pin3_out, 0);
  endtask

  // ==========================================================
  // main sequence
  initial begin
    logic [23:0] d;
    mismatches = 0;
    check_count = 0;
    bus = '{default: '0};
    i_reset_n = 1'b0;
    repeat (12) @(posedge i_clk);
    i_reset_n <= 1'b1;
    @(posedge i_clk);
    #1;
    // defaults: everything off, unity gain, lead one, eighth amplitude
    chk(cfg.measure_enable, 0);
    chk(cfg.periodic_set, 0);
    chk(cfg.gain, 1);
    chk(cfg.amplitude_shift, 3);
    chk(cfg.capacitor_external, 0);
    rd(REG_ADDR, d);
    chk(d, 0);
    // reserved bits never stored; read data lasts one cycle only
    wr(REG_ADDR, 24'hffffff);
    rd(REG_ADDR, d);
    chk(d, 24'h01ffff);
    @(posedge i_clk);
    #1;
    chk(o_rdata, 0);
    chk(cfg.amplifier_bypass, 1);
    chk(cfg.periodic_set, 1);
    // other addresses neither store nor answer
    wr(8'h04, 24'h000000);
    rd(8'h04, d);
    chk(d, 0);
    rd(REG_ADDR, d);
    chk(d, 24'h01ffff);
    // every gain code, listed and unlisted
    for (int g = 0; g < 16; g++) begin
      setw({12'h000, g[3:0], 8'h00});
      chk(cfg.gain, (g < 10) ? g + 1 : 10);
    end
    // every amplitude code
    for (int a = 0; a < 4; a++) begin
      setw({19'h00000, a[1:0], 3'h0});
      chk(cfg.amplitude_shift, 3 - a);
    end
    // every lead code, and the external limb choice
    for (int l = 0; l < 8; l++) begin
      setw({16'h0000, l[2], l[1:0], 5'h00});
      chk(cfg.lead, l[1:0]);
      if (l[1:0] == 2'b11) begin
        chk(cfg.external_right_arm_path, 1);
        chk(cfg.external_left_leg_path, !l[2]);
        chk(cfg.external_left_arm_path, l[2]);
      end else begin
        chk(cfg.external_right_arm_path, 0);
        chk(cfg.external_left_leg_path, 0);
        chk(cfg.external_left_arm_path, 0);
      end
    end
    // drive pairing and capacitor source
    setw(24'h000000);
    chk({cfg.right_arm_drive, cfg.left_leg_drive, cfg.left_arm_drive}, 3'b110);
    setw(24'h002000);
    chk({cfg.right_arm_drive, cfg.left_leg_drive, cfg.left_arm_drive}, 3'b101);
    setw(24'h003000);
    chk(cfg.capacitor_external, 1);
    chk({cfg.right_arm_drive, cfg.left_leg_drive, cfg.left_arm_drive}, 3'b100);
    // enable alone, then each carrier code of both sets
    setw(24'h000001);
    chk(cfg.measure_enable, 1);
    chk(o_pin3_oe, 0);
    for (int i = 0; i < 8; i++) begin
      carrier(i);
    end
    report_and_stop();
  end
endmodule

`default_nettype wire
